// ==== rtl/fdsc_map.svh ====
// Purpose: Constants for the sleep/wake command block
// Assumes: Byte-wide serial commands, MSB first
// Notes:   Timing values are in ns; the 250 MHz system clock has a 4 ns period
`ifndef FDSC_MAP_SVH
`define FDSC_MAP_SVH
`define FDSC_CMD_SLEEP      8'hB9
`define FDSC_CMD_WAKE_ID    8'hAB
`define FDSC_CMD_PARAM_RD   8'h5A
`define FDSC_CMD_RST_EN     8'h66
`define FDSC_CMD_RST        8'h99
`define FDSC_ARRAY_ERASED   8'hFF
`define FDSC_STATUS_RESET   24'h20_0000
`define FDSC_STATUS_DRV_BIT 21
`define FDSC_CLK_PERIOD_NS  4
`define FDSC_SLEEP_DLY_NS   3000
`define FDSC_WAKE_DLY_NS    3000
`define FDSC_WAKE_ID_DLY_NS 3000
`define FDSC_RESET_DLY_NS   3000
`define FDSC_ID_DUMMY_BYTES 3
`define FDSC_DEV_ID         8'h5C
`endif

// ==== rtl/fdsc_pkg.sv ====
// Purpose: Types for the sleep/wake command block
// Assumes: Included map header supplies all numbers
// Notes:   Types only
package fdsc_pkg;
  typedef enum logic [2:0] {
    FDSC_ST_STANDBY,
    FDSC_ST_ENTERING,
    FDSC_ST_SLEEP,
    FDSC_ST_WAKING,
    FDSC_ST_RESETTING
  } fdsc_pwr_t;
endpackage

// ==== rtl/fdsc_delay.sv ====
// Purpose: Loadable down counter for a busy interval
// Assumes: Start is a one-cycle pulse
// Notes:   Busy holds from start until the count runs out
module fdsc_delay #(
  parameter int W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_len,
  output logic              o_busy,
  output logic              o_done
);
  logic [W-1:0] cnt;
  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt    <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= o_busy && (cnt == W'(1)) && !i_start;
      if (i_start)
      begin
        cnt    <= i_len;
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        cnt    <= cnt - W'(1);
        o_busy <= (cnt != W'(1));
      end
    end
  end
endmodule

// ==== rtl/fdsc_top.sv ====
// Purpose: Sleep entry, wake and ID readout command handling of a serial flash
// Assumes: Chip select, serial clock and data in are pins, synchronised here
// Notes:   Link clock is sampled, not used as a clock; ID changes after falling SCK
`include "fdsc_map.svh"
// Operation
// - Only the sleep command enters sleep
// - Chip select high gives standby, not sleep
// - Asleep: ignore all but wake, reset
// - Sleep runs only after exactly eight bits
// - Wait sleep-entry delay before asleep
// - Sleep refused while write in progress
// - Power-up always starts in standby
// - Wake command releases sleep, outputs ID
// - Wake-only: commands after wake delay
// - Opcode, three dummies, then ID MSB-first
// - ID byte repeats until select rises
// - Wake ignored while write in progress
// - Parameter read command is accepted
// - Delivered array reads erased value
// - Delivered status zero except drive bit
// - Reset pair aborts, clears, blocks commands
// - Write-in-progress mirrors internal cycle
module fdsc_top
  import fdsc_pkg::*;
#(
  parameter int unsigned SLEEP_DLY_CYC   = (`FDSC_SLEEP_DLY_NS + `FDSC_CLK_PERIOD_NS - 1) / `FDSC_CLK_PERIOD_NS,
  parameter int unsigned WAKE_DLY_CYC    = (`FDSC_WAKE_DLY_NS + `FDSC_CLK_PERIOD_NS - 1) / `FDSC_CLK_PERIOD_NS,
  parameter int unsigned WAKE_ID_DLY_CYC = (`FDSC_WAKE_ID_DLY_NS + `FDSC_CLK_PERIOD_NS - 1) / `FDSC_CLK_PERIOD_NS,
  parameter int unsigned RESET_DLY_CYC   = (`FDSC_RESET_DLY_NS + `FDSC_CLK_PERIOD_NS - 1) / `FDSC_CLK_PERIOD_NS,
  parameter logic [7:0]  DEVICE_ID       = `FDSC_DEV_ID  // Arbitrary value
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_CS_N,
  input  wire logic        I_SCK,
  input  wire logic        I_SI,
  input  wire logic        I_CYCLE_BUSY,
  input  wire logic        I_CYCLE_ABORT_ACK,
  output logic             O_SO,
  output logic             O_SO_OE,
  output logic             O_SLEEP,
  output logic             O_BUSY,
  output logic             O_WRITE_IN_PROGRESS,
  output logic             O_CYCLE_ABORT,
  output logic             O_PARAM_RD,
  output logic [23:0]      O_STATUS,
  output logic [7:0]       O_ARRAY_FILL,
  output logic             O_CMD_ACCEPT
);
  localparam int DW = 16;
  initial
  begin
    if (SLEEP_DLY_CYC < 1 || SLEEP_DLY_CYC >= (1 << DW) || WAKE_DLY_CYC < 1 || WAKE_DLY_CYC >= (1 << DW) ||
        WAKE_ID_DLY_CYC < 1 || WAKE_ID_DLY_CYC >= (1 << DW) || RESET_DLY_CYC < 1 || RESET_DLY_CYC >= (1 << DW))
      $error("fdsc_top: delay count out of range");
  end
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic       cs_q;
  logic       sck_q;
  // Two stages per pin; the second stage feeds logic, and chip select and serial clock also keep a delayed copy for edges
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h0;
      si_sync  <= 2'h0;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
    end
    else
    begin
      cs_sync  <= {cs_sync[0], I_CS_N};
      sck_sync <= {sck_sync[0], I_SCK};
      si_sync  <= {si_sync[0], I_SI};
      cs_q     <= cs_sync[1];
      sck_q    <= sck_sync[1];
    end
  end
  wire cs_low   = !cs_sync[1];
  wire cs_fall  = cs_q && !cs_sync[1];
  wire cs_rise  = !cs_q && cs_sync[1];
  wire sck_rise = cs_low && !sck_q && sck_sync[1];
  wire sck_fall = cs_low && sck_q && !sck_sync[1];
  // ---------------------------------------------------------------
  // Shift-in of the command and dummy bytes
  // ---------------------------------------------------------------
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [5:0] bit_cnt;   // Saturates; 32 bits cover opcode plus dummies
  logic       op_valid;
  wire [7:0] next_shreg = {shreg[6:0], si_sync[1]};
  wire       last_op_bit = sck_rise && (bit_cnt == 6'd7);
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      shreg    <= 8'h00;
      opcode   <= 8'h00;
      bit_cnt  <= 6'd0;
      op_valid <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_cnt  <= 6'd0;
      op_valid <= 1'b0;
    end
    else if (sck_rise)
    begin
      shreg   <= next_shreg;
      bit_cnt <= (bit_cnt == 6'd63) ? bit_cnt : bit_cnt + 6'd1;
      if (last_op_bit)
      begin
        opcode   <= next_shreg;
        op_valid <= 1'b1;
      end
    end
  end
  // Frame ended exactly after eight bits: only then do sleep, reset enable and reset run
  wire exact_byte = cs_rise && op_valid && (bit_cnt == 6'd8);
  wire id_phase   = op_valid && (opcode == `FDSC_CMD_WAKE_ID) && (bit_cnt >= 6'd32);
  // ---------------------------------------------------------------
  // Power state and decode
  // ---------------------------------------------------------------
  fdsc_pwr_t state;
  fdsc_pwr_t next_state;
  logic      rst_armed;
  logic      dly_start;
  logic [DW-1:0] dly_len;
  logic      dly_busy;
  logic      dly_done;
  wire write_in_progress      = I_CYCLE_BUSY;
  wire asleep   = (state == FDSC_ST_SLEEP);
  wire blocked  = (state == FDSC_ST_ENTERING) || (state == FDSC_ST_WAKING) || (state == FDSC_ST_RESETTING);
  wire is_sleep = exact_byte && (opcode == `FDSC_CMD_SLEEP) && !blocked && !asleep && !write_in_progress;
  wire is_wake  = cs_rise && op_valid && (opcode == `FDSC_CMD_WAKE_ID) && !blocked && !write_in_progress;
  wire is_rsten = exact_byte && (opcode == `FDSC_CMD_RST_EN) && !blocked;
  wire is_rst   = exact_byte && (opcode == `FDSC_CMD_RST) && rst_armed && !blocked;
  wire is_param = last_op_bit && (next_shreg == `FDSC_CMD_PARAM_RD) && !blocked && !asleep;
  wire wake_id  = is_wake && (bit_cnt >= 6'd32);
  // Next state; sleep leaves only through wake or reset
  always_comb
  begin
    next_state = state;
    dly_start  = 1'b0;
    dly_len    = DW'(SLEEP_DLY_CYC);
    case (state)
      FDSC_ST_STANDBY, FDSC_ST_SLEEP:
      begin
        if (is_rst)
        begin
          next_state = FDSC_ST_RESETTING;
          dly_start  = 1'b1;
          dly_len    = DW'(RESET_DLY_CYC);
        end
        else if (is_sleep)
        begin
          next_state = FDSC_ST_ENTERING;
          dly_start  = 1'b1;
        end
        else if (is_wake && asleep)
        begin
          next_state = FDSC_ST_WAKING;
          dly_start  = 1'b1;
          dly_len    = wake_id ? DW'(WAKE_ID_DLY_CYC) : DW'(WAKE_DLY_CYC);
        end
      end
      FDSC_ST_ENTERING:
        if (dly_done)
          next_state = FDSC_ST_SLEEP;
      FDSC_ST_WAKING, FDSC_ST_RESETTING:
        if (dly_done)
          next_state = FDSC_ST_STANDBY;
      default:
        next_state = FDSC_ST_STANDBY;
    endcase
  end
  fdsc_delay #(.W(DW)) u_delay (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_start (dly_start),
    .i_len   (dly_len),
    .o_busy  (dly_busy),
    .o_done  (dly_done)
  );
  // Power-up lands in standby; reset also clears the reset-enable latch
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state        <= FDSC_ST_STANDBY;
      rst_armed    <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      if (is_rsten)
        rst_armed <= 1'b1;
      else if (exact_byte || is_rst)
        rst_armed <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // Serial output: ID byte repeats, MSB first, on falling SCK
  // ---------------------------------------------------------------
  logic [2:0] id_bit;
  wire        id_drive = id_phase && cs_low && !write_in_progress && !blocked;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      id_bit  <= 3'd7;
      O_SO    <= 1'b0;
      O_SO_OE <= 1'b0;
    end
    else
    begin
      O_SO_OE <= id_drive;
      if (!id_phase)
        id_bit <= 3'd7;
      else if (sck_fall)
      begin
        O_SO   <= DEVICE_ID[id_bit];
        id_bit <= id_bit - 3'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status outputs and delivered state
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_SLEEP             <= 1'b0;
      O_BUSY              <= 1'b0;
      O_WRITE_IN_PROGRESS <= 1'b0;
      O_CYCLE_ABORT       <= 1'b0;
      O_PARAM_RD          <= 1'b0;
      O_STATUS            <= `FDSC_STATUS_RESET;
      O_ARRAY_FILL        <= `FDSC_ARRAY_ERASED;
      O_CMD_ACCEPT        <= 1'b0;
    end
    else
    begin
      O_SLEEP             <= (next_state == FDSC_ST_SLEEP);
      O_BUSY              <= dly_busy || dly_start;
      O_WRITE_IN_PROGRESS <= write_in_progress;
      O_CYCLE_ABORT       <= is_rst || (O_CYCLE_ABORT && !I_CYCLE_ABORT_ACK);
      O_PARAM_RD          <= is_param || (O_PARAM_RD && cs_low);
      O_CMD_ACCEPT        <= last_op_bit && !blocked && (!asleep || next_shreg == `FDSC_CMD_WAKE_ID ||
                             next_shreg == `FDSC_CMD_RST_EN || next_shreg == `FDSC_CMD_RST);
      if (is_rst)
        O_STATUS <= `FDSC_STATUS_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_sleep_only_cmd: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state != FDSC_ST_ENTERING) ##1 (state == FDSC_ST_ENTERING) |-> $past(is_sleep))
    else $error("sleep entered without sleep command");
  a_sleep_wip_rej: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (write_in_progress && state == FDSC_ST_STANDBY) |=> (state != FDSC_ST_ENTERING))
    else $error("sleep accepted during write cycle");
  a_sleep_delay: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    is_sleep |=> (state == FDSC_ST_ENTERING) [*8])
    else $error("sleep entered too early");
  a_asleep_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (state == FDSC_ST_SLEEP) |-> !O_SO_OE || $past(id_phase))
    else $error("output driven while asleep");
  a_wake_leaves: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (asleep && is_wake && !is_rst) |=> (state == FDSC_ST_WAKING) ##1 O_BUSY)
    else $error("wake did not release sleep");
  a_busy_blocks: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    blocked |-> O_BUSY && !O_CMD_ACCEPT)
    else $error("command decoded while busy");
  a_status_drv: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_STATUS[`FDSC_STATUS_DRV_BIT] && (O_STATUS == `FDSC_STATUS_RESET))
    else $error("status not in delivered state");
  a_wip_mirror: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    O_WRITE_IN_PROGRESS == $past(I_CYCLE_BUSY))
    else $error("write in progress not mirrored");
endmodule

// ==== tb/fdsc_host.sv ====
// Purpose: Host controller model that frames commands on the serial pins
// Assumes: Link clock idles low and toggles only inside frames
// Notes:   All pin changes land on falling edges of the system clock
module fdsc_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  localparam int HALF = 20;  // 80 ns half period of the 160 ns link clock
  logic so_line;
  // A floating output reads as z, so a missing drive never matches
  assign so_line = i_so_oe ? i_so : 1'bz;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b1;
  end
  // Shift n bits MSB first; from bit 32 on, sample the output line
  task automatic frame(input logic [47:0] v, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_si = v[47-i];
      repeat (HALF) @(negedge i_clk);
      if (i >= 32)
        rd = {rd[14:0], so_line};  // host takes ID bits before rise
      o_sck = 1'b1;
      repeat (HALF) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (HALF) @(negedge i_clk);
    o_cs_n = 1'b1;  // select rises only after the last clocked bit
    o_si   = ~o_si;  // Released data line shows a changed level
  endtask
endmodule

// ==== tb/tb_flash_deep_sleep_and_id_cmds.sv ====
// Purpose: Self-checking bench for sleep, wake and ID readout handling
// Assumes: Short delay counts of 10 cycles keep the run brief
// Notes:   A behavioural sleep model predicts the sleep state after every command
`include "fdsc_map.svh"
module tb_flash_deep_sleep_and_id_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int         DLY    = 10;
  localparam logic [7:0] ID_VAL = 8'h3C;  // Arbitrary identifier value
  logic        clk, rst_n, cs_n, sck, si, cyc_busy, abort_ack, so, so_oe;
  logic        sleep, busy, write_in_progress, abort, param_rd, cmd_acc, saw_param;
  logic [23:0] status;
  logic [7:0]  fill, b;
  logic [15:0] rd;
  int          err_total, n_checks, cyc, n_acc, m_sleep, m_arm;
  fdsc_top #(.SLEEP_DLY_CYC(DLY), .WAKE_DLY_CYC(DLY), .WAKE_ID_DLY_CYC(DLY),
             .RESET_DLY_CYC(DLY), .DEVICE_ID(ID_VAL)) dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si),
    .I_CYCLE_BUSY(cyc_busy), .I_CYCLE_ABORT_ACK(abort_ack), .O_SO(so),
    .O_SO_OE(so_oe), .O_SLEEP(sleep), .O_BUSY(busy), .O_WRITE_IN_PROGRESS(write_in_progress),
    .O_CYCLE_ABORT(abort), .O_PARAM_RD(param_rd), .O_STATUS(status),
    .O_ARRAY_FILL(fill), .O_CMD_ACCEPT(cmd_acc));
  fdsc_host host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  // Clock, accept counter and hang guard
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cmd_acc === 1'b1)
      n_acc++;
    if (param_rd === 1'b1)
      saw_param = 1'b1;
    if (cyc == 40000)
    begin
      err_total++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One command frame; the model decides the sleep state it should leave
  task automatic do_cmd(input logic [7:0] c, input int n, input logic w);
    int a0;
    int old;
    @(negedge clk);
    cyc_busy = w;
    a0  = n_acc;
    old = m_sleep;
    if (n == 8 && c == `FDSC_CMD_SLEEP && !w && m_sleep == 0)
      m_sleep = 1;
    else if (n == 8 && c == `FDSC_CMD_WAKE_ID && !w)
      m_sleep = 0;
    else if (n == 8 && c == `FDSC_CMD_RST && m_arm == 1)
      m_sleep = 0;
    m_arm = (n == 8 && c == `FDSC_CMD_RST_EN);
    host.frame({c, 40'h0}, n, rd);
    repeat (8) @(negedge clk);
    if (old != m_sleep)
    begin
      chk(busy, 1);
      chk(sleep, 0);
    end
    // Select stays high through the whole delay before the next frame
    repeat (3 * DLY) @(negedge clk);
    chk(sleep, m_sleep);
    chk(busy, 0);
    chk(write_in_progress, w);
    chk(so_oe, 0);
    if (old == 1 && !(c inside {`FDSC_CMD_WAKE_ID, `FDSC_CMD_RST_EN, `FDSC_CMD_RST}))
      chk(24'(n_acc - a0), 0);
    else
      chk(24'(n_acc - a0), (n >= 8) ? 24'h000001 : 24'h000000);
  endtask
  // Opcode, three random dummy bytes, then two identifier bytes
  task automatic id_read();
    host.frame({`FDSC_CMD_WAKE_ID, 24'($urandom), 16'h0000}, 48, rd);
    chk(rd, {ID_VAL, ID_VAL});
    m_sleep = 0;
    repeat (3 * DLY + 8) @(negedge clk);
    chk(sleep, 0);
    chk(busy, 0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    cyc_busy = 1'b0;
    abort_ack = 1'b0;
    saw_param = 1'b0;
    {err_total, n_checks, cyc, n_acc, m_sleep, m_arm} = '0;
    void'($urandom(32'h27829F7A));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(sleep, 0);
    chk(status, 24'h200000);
    chk(fill, 8'hFF);
    chk(so_oe, 0);
    do_cmd(`FDSC_CMD_SLEEP, 7, 0);
    do_cmd(`FDSC_CMD_SLEEP, 9, 0);
    // Random other opcodes never put the part to sleep
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($urandom);
      if (b inside {`FDSC_CMD_SLEEP, `FDSC_CMD_WAKE_ID, `FDSC_CMD_RST_EN, `FDSC_CMD_RST, `FDSC_CMD_PARAM_RD})
        b = 8'h06;
      do_cmd(b, 8, 0);
    end
    do_cmd(`FDSC_CMD_SLEEP, 8, 1);
    do_cmd(`FDSC_CMD_SLEEP, 8, 0);
    do_cmd(`FDSC_CMD_PARAM_RD, 8, 0);
    do_cmd(8'h02, 8, 0);
    chk(saw_param, 0);
    do_cmd(`FDSC_CMD_WAKE_ID, 8, 1);
    do_cmd(`FDSC_CMD_WAKE_ID, 8, 0);
    do_cmd(`FDSC_CMD_PARAM_RD, 8, 0);
    chk(saw_param, 1);
    id_read();
    do_cmd(`FDSC_CMD_SLEEP, 8, 0);
    id_read();
    do_cmd(`FDSC_CMD_SLEEP, 8, 0);
    do_cmd(`FDSC_CMD_RST_EN, 8, 0);
    do_cmd(`FDSC_CMD_RST, 8, 0);
    chk(abort, 1);
    chk(status, 24'h200000);
    abort_ack = 1'b1;
    repeat (4) @(negedge clk);
    abort_ack = 1'b0;
    repeat (4) @(negedge clk);
    chk(abort, 0);
    // Power loss while asleep: the part must come back in standby
    do_cmd(`FDSC_CMD_SLEEP, 8, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    m_sleep = 0;
    m_arm = 0;
    repeat (3) @(negedge clk);
    chk(sleep, m_sleep);
    chk(busy, 0);
    do_cmd(8'h02, 8, 0);
    summarize();
  end
endmodule
